// [design/timer_io_function_select.sv]
/*
 * Timer I/O function select: function code registers for channel 0
 * register C and channel 1 registers A and B, the buffer-mode bit of
 * channel 0, and three pin function units, behind a classic Wishbone slave.
 * Assumes counters and compare comparators live outside and deliver
 * synchronous counts, compare-match pulses and count up/down pulses.
 */
// The placing of the registers and the Wishbone slave port were left to the implementer.
//
// Overview of operation
// - upper nibble of the register C control reads zero, writes ignored
// - lower nibble of register C control selects compare or capture behaviour
// - code 0000 disables the pin output and is the reset value
// - codes 0001..0011 start pin low, then drive 0, 1 or toggle on match
// - code 0100 disables output; 0101..0111 start high, then 0, 1 or toggle
// - code 1000 captures the counter on a rising pin edge
// - code 1001 captures the counter on a falling pin edge
// - code 1010 captures the counter on both pin edges
// - in buffer mode A register C ignores its code, no compare or capture
// - channel 1 upper nibble sets register B; 11xx capture on register C events
// - channel 1 lower nibble sets register A, pin capture from its own pin
// - register A of channel 1 codes 11xx capture on channel 0 A events
// - mode register bit 4 selects normal or A/C buffer operation
//
`timescale 1ns/1ps
module timer_io_function_select (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [timer_io_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [timer_io_pkg::DATA_W-1:0] wb_dat_i,
    output logic [timer_io_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // counter values and counter events
    input wire logic [timer_io_pkg::COUNT_W-1:0] chan0_count_i,
    input wire logic [timer_io_pkg::COUNT_W-1:0] chan1_count_i,
    input wire logic chan1_count_up_i,
    input wire logic chan1_count_down_i,
    // compare-match pulses from the comparators
    input wire logic chan0_general_a_match_i,
    input wire logic chan0_general_c_match_i,
    input wire logic chan1_general_a_match_i,
    input wire logic chan1_general_b_match_i,
    // channel 0 register A capture pulse
    input wire logic chan0_general_a_capture_i,
    // timer pins, input side
    input wire logic chan0_pin_c_i,
    input wire logic chan1_pin_a_i,
    input wire logic chan1_pin_b_i,
    // timer pins, output side
    output logic chan0_pin_c_o,
    output logic chan0_pin_c_oe_n_o,
    output logic chan1_pin_a_o,
    output logic chan1_pin_a_oe_n_o,
    output logic chan1_pin_b_o,
    output logic chan1_pin_b_oe_n_o,
    // capture strobes and buffer mode to the counter logic
    output logic chan0_general_c_capture_o,
    output logic chan1_general_a_capture_o,
    output logic chan1_general_b_capture_o,
    output logic buffer_op_a_o
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [timer_io_pkg::CODE_W-1:0] regc_function_code;
    logic [timer_io_pkg::CODE_W-1:0] rega_function_code;
    logic [timer_io_pkg::CODE_W-1:0] regb_function_code;
    logic buffer_op_a;
    logic [timer_io_pkg::EVT_W-1:0] event_status;
    logic [timer_io_pkg::EVT_W-1:0] next_event_status;
    logic [timer_io_pkg::EVT_W-1:0] event_set;
    logic [timer_io_pkg::EVT_W-1:0] event_clear;

    // bus decode
    logic bus_req;
    logic bus_write;
    logic [timer_io_pkg::DATA_W-1:0] next_dat;

    // unit connections
    timer_io_pkg::unit_in_s unit_c_in;
    timer_io_pkg::unit_in_s unit_1a_in;
    timer_io_pkg::unit_in_s unit_1b_in;
    timer_io_pkg::unit_out_s unit_c_out;
    timer_io_pkg::unit_out_s unit_1a_out;
    timer_io_pkg::unit_out_s unit_1b_out;

    // ------------------------------------------------------------------
    // wishbone handshake
    // ------------------------------------------------------------------

    // a request is taken in the cycle before ack; ack drops the next cycle
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_req && wb_we_i && wb_sel_i[0];

    // single-cycle answer, every address acknowledged so a stray access never hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // ------------------------------------------------------------------
    // function code registers
    // ------------------------------------------------------------------

    // register C control: only the low nibble is stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regc_function_code <= timer_io_pkg::RST_IO_CONTROL[3:0];
        end else if (bus_write && (wb_adr_i == timer_io_pkg::OFS_CHAN0_REGC_IO_CONTROL)) begin
            regc_function_code <= wb_dat_i[timer_io_pkg::REGC_CODE_LSB +: timer_io_pkg::CODE_W];
        end
    end

    // channel 1 control: both nibbles writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rega_function_code <= timer_io_pkg::RST_IO_CONTROL[3:0];
            regb_function_code <= timer_io_pkg::RST_IO_CONTROL[7:4];
        end else if (bus_write && (wb_adr_i == timer_io_pkg::OFS_CHAN1_IO_CONTROL)) begin
            rega_function_code <= wb_dat_i[timer_io_pkg::REGA_CODE_LSB +: timer_io_pkg::CODE_W];
            regb_function_code <= wb_dat_i[timer_io_pkg::REGB_CODE_LSB +: timer_io_pkg::CODE_W];
        end
    end

    // mode register: only the buffer A bit lives here, the rest stays elsewhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buffer_op_a <= timer_io_pkg::RST_BUFFER_OP_A;
        end else if (bus_write && (wb_adr_i == timer_io_pkg::OFS_CHAN0_MODE_REGISTER)) begin
            buffer_op_a <= wb_dat_i[timer_io_pkg::BUFFER_OP_A_BIT];
        end
    end

    // buffer mode is forwarded so the counter logic can pair A with C
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buffer_op_a_o <= timer_io_pkg::RST_BUFFER_OP_A;
        end else begin
            buffer_op_a_o <= buffer_op_a;
        end
    end

    // ------------------------------------------------------------------
    // sticky event flags
    // ------------------------------------------------------------------

    // hardware set beats a write-one clear landing in the same cycle
    always_comb begin
        event_set = '0;
        event_set[timer_io_pkg::EVT_CAPTURE_LSB + 0] = unit_c_out.capture_strobe;
        event_set[timer_io_pkg::EVT_CAPTURE_LSB + 1] = unit_1a_out.capture_strobe;
        event_set[timer_io_pkg::EVT_CAPTURE_LSB + 2] = unit_1b_out.capture_strobe;
        event_set[timer_io_pkg::EVT_COMPARE_LSB + 0] = unit_c_out.compare_strobe;
        event_set[timer_io_pkg::EVT_COMPARE_LSB + 1] = unit_1a_out.compare_strobe;
        event_set[timer_io_pkg::EVT_COMPARE_LSB + 2] = unit_1b_out.compare_strobe;
        event_clear = '0;
        if (bus_write && (wb_adr_i == timer_io_pkg::OFS_EVENT_STATUS)) begin
            event_clear = wb_dat_i[timer_io_pkg::EVT_W-1:0];
        end
        next_event_status = (event_status & ~event_clear) | event_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_status <= timer_io_pkg::RST_EVENT_STATUS;
        end else begin
            event_status <= next_event_status;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------

    // unmapped offsets read zero; narrow registers sit in the low bits
    always_comb begin
        next_dat = '0;
        case (wb_adr_i)
            timer_io_pkg::OFS_CHAN0_REGC_IO_CONTROL: begin
                next_dat[7:0] = {4'h0, regc_function_code};
            end
            timer_io_pkg::OFS_CHAN1_IO_CONTROL: begin
                next_dat[7:0] = {regb_function_code, rega_function_code};
            end
            timer_io_pkg::OFS_CHAN0_MODE_REGISTER: begin
                next_dat[7:0] = timer_io_pkg::MODE_RESERVED_ONES;
                next_dat[timer_io_pkg::BUFFER_OP_A_BIT] = buffer_op_a;
            end
            timer_io_pkg::OFS_EVENT_STATUS: begin
                next_dat[timer_io_pkg::EVT_W-1:0] = event_status;
            end
            timer_io_pkg::OFS_CAPTURE_C: begin
                next_dat[timer_io_pkg::COUNT_W-1:0] = unit_c_out.captured;
            end
            timer_io_pkg::OFS_CAPTURE_1A: begin
                next_dat[timer_io_pkg::COUNT_W-1:0] = unit_1a_out.captured;
            end
            timer_io_pkg::OFS_CAPTURE_1B: begin
                next_dat[timer_io_pkg::COUNT_W-1:0] = unit_1b_out.captured;
            end
            timer_io_pkg::OFS_PIN_STATUS: begin
                next_dat[5:0] = {unit_1b_out.pin_oe_n, unit_1a_out.pin_oe_n, unit_c_out.pin_oe_n,
                                 unit_1b_out.pin_out, unit_1a_out.pin_out, unit_c_out.pin_out};
            end
            default: next_dat = '0;
        endcase
    end

    // data is registered with ack and held at zero between answers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_dat;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // event routing into the units
    // ------------------------------------------------------------------

    // register C: own pin, internal source is channel 1 counting
    always_comb begin
        unit_c_in.compare_match = chan0_general_c_match_i;
        unit_c_in.internal_event = chan1_count_up_i || chan1_count_down_i;
        unit_c_in.pin_in = chan0_pin_c_i;
        unit_c_in.count = chan0_count_i;
    end

    // channel 1 register A: internal source is channel 0 register A
    always_comb begin
        unit_1a_in.compare_match = chan1_general_a_match_i;
        unit_1a_in.internal_event = chan0_general_a_match_i || chan0_general_a_capture_i;
        unit_1a_in.pin_in = chan1_pin_a_i;
        unit_1a_in.count = chan1_count_i;
    end

    // channel 1 register B: internal source is register C; its strobes lag one cycle
    always_comb begin
        unit_1b_in.compare_match = chan1_general_b_match_i;
        unit_1b_in.internal_event = unit_c_out.compare_strobe || unit_c_out.capture_strobe;
        unit_1b_in.pin_in = chan1_pin_b_i;
        unit_1b_in.count = chan1_count_i;
    end

    // ------------------------------------------------------------------
    // function units
    // ------------------------------------------------------------------

    // register C is silenced while it serves as the buffer of register A
    io_function_unit u_unit_c (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i(regc_function_code),
        .inhibit_i(buffer_op_a),
        .ev_i(unit_c_in),
        .res_o(unit_c_out)
    );

    io_function_unit u_unit_1a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i(rega_function_code),
        .inhibit_i(1'b0),
        .ev_i(unit_1a_in),
        .res_o(unit_1a_out)
    );

    io_function_unit u_unit_1b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i(regb_function_code),
        .inhibit_i(1'b0),
        .ev_i(unit_1b_in),
        .res_o(unit_1b_out)
    );

    // ------------------------------------------------------------------
    // pin and strobe outputs, all from unit flip-flops
    // ------------------------------------------------------------------
    assign chan0_pin_c_o = unit_c_out.pin_out;
    assign chan0_pin_c_oe_n_o = unit_c_out.pin_oe_n;
    assign chan1_pin_a_o = unit_1a_out.pin_out;
    assign chan1_pin_a_oe_n_o = unit_1a_out.pin_oe_n;
    assign chan1_pin_b_o = unit_1b_out.pin_out;
    assign chan1_pin_b_oe_n_o = unit_1b_out.pin_oe_n;
    assign chan0_general_c_capture_o = unit_c_out.capture_strobe;
    assign chan1_general_a_capture_o = unit_1a_out.capture_strobe;
    assign chan1_general_b_capture_o = unit_1b_out.capture_strobe;

endmodule : timer_io_function_select

// [include/timer_io_pkg.sv]
/*
 * Constants, field layout and carrier structs of the timer I/O select.
 * Assumes a 32-bit Wishbone bus and 16-bit counters.
 */
package timer_io_pkg;

    // ----
    // widths
    // ----
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CODE_W = 4;
    localparam int unsigned COUNT_W = 16;
    localparam int unsigned EVT_W = 6;

    // ----
    // register byte offsets
    // ----
    localparam logic [7:0] OFS_CHAN0_REGC_IO_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CHAN1_IO_CONTROL = 8'h04;
    localparam logic [7:0] OFS_CHAN0_MODE_REGISTER = 8'h08;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CAPTURE_C = 8'h10;
    localparam logic [7:0] OFS_CAPTURE_1A = 8'h14;
    localparam logic [7:0] OFS_CAPTURE_1B = 8'h18;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h1C;

    // ----
    // reset values
    // ----
    localparam logic [7:0] RST_IO_CONTROL = 8'h00;
    localparam logic RST_BUFFER_OP_A = 1'b0;
    localparam logic [7:0] MODE_RESERVED_ONES = 8'hC0;
    localparam logic [EVT_W-1:0] RST_EVENT_STATUS = 6'h00;

    // ----
    // field positions
    // ----
    localparam int unsigned REGA_CODE_LSB = 0;
    localparam int unsigned REGB_CODE_LSB = 4;
    localparam int unsigned REGC_CODE_LSB = 0;
    localparam int unsigned BUFFER_OP_A_BIT = 4;
    localparam int unsigned CODE_CAPTURE_BIT = 3;
    localparam int unsigned CODE_EVENT_BIT = 2;
    localparam int unsigned CODE_INIT_LEVEL_BIT = 2;
    localparam int unsigned EVT_CAPTURE_LSB = 0;
    localparam int unsigned EVT_COMPARE_LSB = 3;

    // ----
    // low two code bits: compare action or capture edge
    // ----
    localparam logic [1:0] ACT_DRIVE0 = 2'h1;
    localparam logic [1:0] ACT_DRIVE1 = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // ----
    // types
    // ----
    typedef enum logic [1:0] {
        MODE_OUTPUT_OFF,
        MODE_COMPARE,
        MODE_CAPTURE_PIN,
        MODE_CAPTURE_EVENT
    } io_mode_e;

    typedef struct packed {
        logic compare_match;
        logic internal_event;
        logic pin_in;
        logic [COUNT_W-1:0] count;
    } unit_in_s;

    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
        logic compare_strobe;
        logic capture_strobe;
        logic [COUNT_W-1:0] captured;
    } unit_out_s;

endpackage : timer_io_pkg

// [design/io_function_unit.sv]
/*
 * One general register's pin function: decodes a 4-bit function code into
 * output compare (initial level, drive 0/1/toggle) or input capture
 * (pin edge or internal event) and holds the captured counter value.
 * Assumes pin and event inputs are synchronous to clk_i.
 */
`timescale 1ns/1ps
module io_function_unit (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic [timer_io_pkg::CODE_W-1:0] code_i,
    input wire logic inhibit_i,
    // events and result
    input wire timer_io_pkg::unit_in_s ev_i,
    output timer_io_pkg::unit_out_s res_o
);

    // ----
    // mode decode
    // ----
    timer_io_pkg::io_mode_e mode;
    logic [timer_io_pkg::CODE_W-1:0] prev_code;
    logic prev_inhibit;
    logic prev_pin;
    logic load_initial;
    logic rise;
    logic fall;
    logic trigger;

    // inhibit wins over any code, so a buffer register never compares
    always_comb begin
        mode = timer_io_pkg::MODE_OUTPUT_OFF;
        if (inhibit_i) begin
            mode = timer_io_pkg::MODE_OUTPUT_OFF;
        end else if (code_i[timer_io_pkg::CODE_CAPTURE_BIT]) begin
            mode = code_i[timer_io_pkg::CODE_EVENT_BIT] ? timer_io_pkg::MODE_CAPTURE_EVENT
                                                        : timer_io_pkg::MODE_CAPTURE_PIN;
        end else if (code_i[1:0] != 2'h0) begin
            mode = timer_io_pkg::MODE_COMPARE; // x000 and x100 keep the pin off
        end
    end

    // initial level is loaded whenever a compare setting takes effect
    assign load_initial = (mode == timer_io_pkg::MODE_COMPARE) &&
                          ((code_i != prev_code) || (inhibit_i != prev_inhibit));
    assign rise = ev_i.pin_in && !prev_pin;
    assign fall = !ev_i.pin_in && prev_pin;

    // capture trigger select
    always_comb begin
        trigger = 1'b0;
        case (mode)
            timer_io_pkg::MODE_CAPTURE_PIN: begin
                if (code_i[1:0] == timer_io_pkg::EDGE_RISE) begin
                    trigger = rise;
                end else if (code_i[1:0] == timer_io_pkg::EDGE_FALL) begin
                    trigger = fall;
                end else begin
                    trigger = rise || fall; // 101x: both edges
                end
            end
            timer_io_pkg::MODE_CAPTURE_EVENT: trigger = ev_i.internal_event;
            default: trigger = 1'b0;
        endcase
    end

    // ----
    // history
    // ----
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_code <= 4'h0;
            prev_inhibit <= 1'b0;
            prev_pin <= 1'b0;
        end else begin
            prev_code <= code_i;
            prev_inhibit <= inhibit_i;
            prev_pin <= ev_i.pin_in;
        end
    end

    // ----
    // output compare pin
    // ----
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_o.pin_out <= 1'b0;
            res_o.pin_oe_n <= 1'b1;
            res_o.compare_strobe <= 1'b0;
        end else begin
            res_o.pin_oe_n <= (mode != timer_io_pkg::MODE_COMPARE);
            res_o.compare_strobe <= (mode == timer_io_pkg::MODE_COMPARE) && ev_i.compare_match;
            if (load_initial) begin
                res_o.pin_out <= code_i[timer_io_pkg::CODE_INIT_LEVEL_BIT]; // initial level first
            end else if ((mode == timer_io_pkg::MODE_COMPARE) && ev_i.compare_match) begin
                case (code_i[1:0])
                    timer_io_pkg::ACT_DRIVE0: res_o.pin_out <= 1'b0;
                    timer_io_pkg::ACT_DRIVE1: res_o.pin_out <= 1'b1;
                    timer_io_pkg::ACT_TOGGLE: res_o.pin_out <= !res_o.pin_out;
                    default: res_o.pin_out <= res_o.pin_out;
                endcase
            end
        end
    end

    // ----
    // input capture
    // ----
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_o.capture_strobe <= 1'b0;
            res_o.captured <= 16'h0000;
        end else begin
            res_o.capture_strobe <= trigger;
            if (trigger) begin
                res_o.captured <= ev_i.count;
            end
        end
    end

endmodule : io_function_unit

// [tb/timer_io_chk.sv]
/* port checker for channel 1 register a of the function select block.
   assumes it is bound to the block's top module, one clock domain. */
`timescale 1ns/1ps
module timer_io_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus writes
    input wire logic wb_cyc_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // register a pin unit
    input wire logic chan1_pin_a_i,
    input wire logic chan1_general_a_match_i,
    input wire logic chan1_pin_a_o,
    input wire logic chan1_pin_a_oe_n_o,
    input wire logic chan1_general_a_capture_o
);
    logic [3:0] code;
    // shadow code lags by a cycle, so every check waits for an idle bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code <= 4'h0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h04) begin
            code <= wb_dat_i[3:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_match(logic [1:0] act);
        !wb_cyc_i && !code[3] && code[1:0] == act && chan1_general_a_match_i;
    endsequence
    sequence s_cap(logic [3:0] c);
        !wb_cyc_i && code == c;
    endsequence
    a_pin_drive0: assert property (s_match(2'h1) |=> !chan1_pin_a_o)
        else $error("drive low missed");
    a_pin_drive1: assert property (s_match(2'h2) |=> chan1_pin_a_o)
        else $error("drive high missed");
    a_pin_toggle: assert property (s_match(2'h3) |=> chan1_pin_a_o != $past(chan1_pin_a_o))
        else $error("toggle missed");
    a_pin_holds: assert property (!$past(chan1_general_a_match_i) && !$past(wb_cyc_i) &&
        !$past(wb_cyc_i, 2) |-> $stable(chan1_pin_a_o)) else $error("pin moved without cause");
    a_oe_follows: assert property (!wb_cyc_i |-> chan1_pin_a_oe_n_o == (code[3] || code[1:0] == 2'h0))
        else $error("pin enable wrong");
    a_cap_rise: assert property (s_cap(4'h8) ##0 $rose(chan1_pin_a_i) |=> chan1_general_a_capture_o)
        else $error("rising capture missed");
    a_cap_fall: assert property (s_cap(4'h9) ##0 $fell(chan1_pin_a_i) |=> chan1_general_a_capture_o)
        else $error("falling capture missed");
    a_cap_both: assert property (s_cap(4'ha) ##0 $changed(chan1_pin_a_i) |=> chan1_general_a_capture_o)
        else $error("edge capture missed");
endmodule : timer_io_chk

bind timer_io_function_select timer_io_chk chk (.*);

// [tb/timer_pin_side.sv]
/* outside world of the three timer pins.
   assumes each released pin is held by an outside driver. */
`timescale 1ns/1ps
module timer_pin_side (
    // outside levels and block drivers
    input wire logic [2:0] ext_i,
    input wire logic [2:0] drv_i,
    input wire logic [2:0] oe_n_i,
    // wire levels
    output logic [2:0] wire_o
);
    // the block wins where it drives, elsewhere the outside level shows
    assign wire_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule : timer_pin_side

// [tb/timer_io_function_select_bench.sv]
/* self-checking bench for the function select block with a pin model.
   assumes the pin side module and the bound checker. */
`timescale 1ns/1ps
module timer_io_function_select_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, bufa, lvl;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic [15:0] c0cnt = 16'h0000, c1cnt = 16'h0000;
    logic [6:0] ev = 7'h00;
    logic [2:0] ext = 3'h0, pin, po, oe_n, cap;
    logic [3:0] c;
    int n_mismatch = 0, n_checks = 0;
    timer_io_function_select dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .chan0_count_i(c0cnt), .chan1_count_i(c1cnt), .chan1_count_up_i(ev[0]), .chan1_count_down_i(ev[1]),
        .chan0_general_a_match_i(ev[2]), .chan0_general_c_match_i(ev[3]), .chan1_general_a_match_i(ev[4]),
        .chan1_general_b_match_i(ev[5]), .chan0_general_a_capture_i(ev[6]), .chan0_pin_c_i(pin[0]),
        .chan1_pin_a_i(pin[1]), .chan1_pin_b_i(pin[2]), .chan0_pin_c_o(po[0]), .chan0_pin_c_oe_n_o(oe_n[0]),
        .chan1_pin_a_o(po[1]), .chan1_pin_a_oe_n_o(oe_n[1]), .chan1_pin_b_o(po[2]), .chan1_pin_b_oe_n_o(oe_n[2]),
        .chan0_general_c_capture_o(cap[0]), .chan1_general_a_capture_o(cap[1]),
        .chan1_general_b_capture_o(cap[2]), .buffer_op_a_o(bufa));
    timer_pin_side far (.ext_i(ext), .drv_i(po), .oe_n_i(oe_n), .wire_o(pin));
    // free-running 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    // one classic cycle; waits on ack with no assumed latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        check(nm, e, q);
    endtask : rd
    // one-cycle event pulse plus new pin levels; outputs settle a cycle later
    task automatic kick(input logic [6:0] v, input logic [2:0] x);
        ev <= v;
        ext <= x;
        @(posedge clk_i);
        ev <= 7'h00;
        @(posedge clk_i);
    endtask : kick
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // a hang costs a mismatch; the tests need under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(64934));
        c0cnt <= 16'($urandom);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(timer_io_pkg::OFS_CHAN1_IO_CONTROL, 32'h0000_0000, "chan1 control reset");
        rd(timer_io_pkg::OFS_CHAN0_MODE_REGISTER, 32'h0000_00c0, "mode reset");
        bus(1'b1, timer_io_pkg::OFS_CHAN0_REGC_IO_CONTROL, 32'h0000_00ff);
        rd(timer_io_pkg::OFS_CHAN0_REGC_IO_CONTROL, 32'h0000_000f, "reg c control");
        rd(8'h40, 32'h0000_0000, "unmapped");
        // every register a code: two matches, a rising and a falling pin edge
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            c1cnt <= 16'($urandom);
            bus(1'b1, timer_io_pkg::OFS_CHAN1_IO_CONTROL, {28'h000_0000, c});
            lvl = c[2];
            check("oe a", c[3] || c[1:0] == 2'h0, oe_n[1]);
            for (int j = 0; j < 3; j++) begin
                kick(j == 0 ? 7'h14 : (j == 1 ? 7'h10 : 7'h40), j == 1 ? 3'h2 : 3'h0);
                if (j < 2 && !c[3] && c[1:0] != 2'h0) lvl = (c[1:0] == 2'h3) ? !lvl : c[1];
                if (!c[3] && c[1:0] != 2'h0) check("pin a", lvl, po[1]);
                check("capture a", c[3] && (c[2] ? j != 1 : (j == 1 ? c[1:0] != 2'h1 : j == 2 && c[1:0] != 2'h0)),
                    cap[1]);
            end
        end
        rd(timer_io_pkg::OFS_CAPTURE_1A, {16'h0000, c1cnt}, "captured 1a");
        // register c on counter events, register b chained on register c
        bus(1'b1, timer_io_pkg::OFS_CHAN0_REGC_IO_CONTROL, 32'h0000_000c);
        bus(1'b1, timer_io_pkg::OFS_CHAN1_IO_CONTROL, 32'h0000_00c0);
        check("oe b", 1'b1, oe_n[2]);
        for (int j = 0; j < 2; j++) begin
            kick(7'(1 << j), 3'h0);
            check("capture c", 1'b1, cap[0]);
            @(posedge clk_i);
            check("capture b", 1'b1, cap[2]);
        end
        rd(timer_io_pkg::OFS_EVENT_STATUS, 32'h0000_0017, "event status");
        rd(timer_io_pkg::OFS_CAPTURE_C, {16'h0000, c0cnt}, "captured c");
        // buffer mode silences register c, release restores it
        bus(1'b1, timer_io_pkg::OFS_CHAN0_MODE_REGISTER, 32'h0000_0010);
        rd(timer_io_pkg::OFS_CHAN0_MODE_REGISTER, 32'h0000_00d0, "mode buffer");
        check("buffer flag", 1'b1, bufa);
        kick(7'h01, 3'h0);
        check("capture c buffered", 1'b0, cap[0]);
        bus(1'b1, timer_io_pkg::OFS_CHAN0_REGC_IO_CONTROL, 32'h0000_0006);
        kick(7'h08, 3'h0);
        check("oe c buffered", 1'b1, oe_n[0]);
        bus(1'b1, timer_io_pkg::OFS_CHAN0_MODE_REGISTER, 32'h0000_0000);
        kick(7'h08, 3'h0);
        check("oe c", 1'b0, oe_n[0]);
        check("pin c", 1'b1, po[0]);
        conclude();
    end
endmodule : timer_io_function_select_bench
